// File: design/bsrs_cfg.svh
// constants for the boot strap reset sequencer
// ==========================================================================
// Summary of operation
// - latch three strap pins three clocks after internal reset release
// - strap pins pulled up, open reads one
// - on failure advance; default emmc, nor, sd, usb
// - sd low, nor low: sd nor emmc usb
// - sd low, nor high: sd emmc nor usb
// - usb low, sd high: usb first, sd last
// - usb, sd high: sd third, usb fourth
// - hold reset output low while supply low
// - keep reset low 156 ms after supply good
// ==========================================================================
`ifndef BSRS_CFG_SVH
`define BSRS_CFG_SVH

`define BSRS_CLK_HZ          25000000
`define BSRS_POR_DELAY_MS    156
`define BSRS_POR_MIN_MS      109
`define BSRS_POR_MAX_MS      218
`define BSRS_EXT_RST_MIN_MS  30
`define BSRS_POR_CYCLES      ((`BSRS_CLK_HZ / 1000) * `BSRS_POR_DELAY_MS)
`define BSRS_STRAP_RESET     3'h7
`define BSRS_NOR_BIT         0
`define BSRS_SD_BIT          1
`define BSRS_USB_BIT         2

`endif

// File: design/bsrs_pkg.sv
// types for the boot strap reset sequencer
package bsrs_pkg;
	typedef enum logic [1:0] {
		BSRS_SRC_EMMC,
		BSRS_SRC_SD,
		BSRS_SRC_NOR,
		BSRS_SRC_USB
	} bsrs_src_t;

	typedef enum logic [1:0] {
		BSRS_ST_IDLE,
		BSRS_ST_TRY,
		BSRS_ST_DONE,
		BSRS_ST_EXHAUSTED
	} bsrs_state_t;
endpackage

// File: design/bsrs_order_decode.sv
// decodes the captured strap code into an ordered list of boot sources
`timescale 1ns/1ps
`default_nettype none
`include "bsrs_cfg.svh"
module bsrs_order_decode (
	input  wire logic [2:0]          i_code,
	input  wire logic [1:0]          i_slot,
	output var bsrs_pkg::bsrs_src_t  o_src
);
	logic nor_first_n;
	logic sd_first_n;
	logic usb_first_n;
	bsrs_pkg::bsrs_src_t order [4];

	assign nor_first_n = i_code[`BSRS_NOR_BIT];
	assign sd_first_n  = i_code[`BSRS_SD_BIT];
	assign usb_first_n = i_code[`BSRS_USB_BIT];

	always_comb begin
		if (!sd_first_n) begin
			// usb-first level is ignored once sd is forced first
			order[0] = bsrs_pkg::BSRS_SRC_SD;
			order[1] = nor_first_n ? bsrs_pkg::BSRS_SRC_EMMC : bsrs_pkg::BSRS_SRC_NOR;
			order[2] = nor_first_n ? bsrs_pkg::BSRS_SRC_NOR : bsrs_pkg::BSRS_SRC_EMMC;
			order[3] = bsrs_pkg::BSRS_SRC_USB;
		end else if (!usb_first_n) begin
			order[0] = bsrs_pkg::BSRS_SRC_USB;
			order[1] = nor_first_n ? bsrs_pkg::BSRS_SRC_EMMC : bsrs_pkg::BSRS_SRC_NOR;
			order[2] = nor_first_n ? bsrs_pkg::BSRS_SRC_NOR : bsrs_pkg::BSRS_SRC_EMMC;
			order[3] = bsrs_pkg::BSRS_SRC_SD;
		end else begin
			order[0] = nor_first_n ? bsrs_pkg::BSRS_SRC_EMMC : bsrs_pkg::BSRS_SRC_NOR;
			order[1] = nor_first_n ? bsrs_pkg::BSRS_SRC_NOR : bsrs_pkg::BSRS_SRC_EMMC;
			order[2] = bsrs_pkg::BSRS_SRC_SD;
			order[3] = bsrs_pkg::BSRS_SRC_USB;
		end
		o_src = order[i_slot];
	end
endmodule
`default_nettype wire

// File: design/bsrs_top.sv
// boot strap capture, boot source stepping and power-on reset delay
`timescale 1ns/1ps
`default_nettype none
`include "bsrs_cfg.svh"
module bsrs_top #(
	parameter int unsigned POR_CYCLES = `BSRS_POR_CYCLES
) (
	input  wire logic                 i_core_clk,
	input  wire logic                 i_arst_n,
	input  wire logic                 i_supply_good,
	input  wire logic                 i_strap_pin_a,
	input  wire logic                 i_strap_pin_b,
	input  wire logic                 i_strap_pin_c,
	input  wire logic                 i_boot_start,
	input  wire logic                 i_boot_fail,
	input  wire logic                 i_boot_ok,
	output logic                      o_por_out_n,
	output logic [2:0]                o_boot_strap_config,
	output var bsrs_pkg::bsrs_src_t   o_boot_src,
	output logic                      o_boot_src_valid,
	output logic                      o_boot_done,
	output logic                      o_boot_exhausted
);
	// ======================================================================
	// reset release
	logic       rst_s1_q;
	logic       rst_n_q;

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	// ======================================================================
	// pin synchronisers
	// a floating strap pin is modelled as a one: the pad pull-up drives it high
	logic [3:0] pin_s1_q;
	logic [3:0] pin_s2_q;
	logic [3:0] pin_raw;

	assign pin_raw = {i_supply_good, i_strap_pin_c, i_strap_pin_b, i_strap_pin_a};

	always_ff @(posedge i_core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pin_s1_q <= {1'b0, `BSRS_STRAP_RESET};
			pin_s2_q <= {1'b0, `BSRS_STRAP_RESET};
		end else begin
			pin_s1_q <= pin_raw;
			pin_s2_q <= pin_s1_q;
		end
	end

	// ======================================================================
	// strap capture, once per reset release
	// capture waits for the synchroniser to fill so released-reset pins are seen
	logic [1:0] cap_wait_q;
	logic       captured_q;
	logic [2:0] code_q;

	always_ff @(posedge i_core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cap_wait_q <= 2'h0;
			captured_q <= 1'b0;
			code_q     <= `BSRS_STRAP_RESET;
		end else if (!captured_q) begin
			if (cap_wait_q == 2'h2) begin
				captured_q <= 1'b1;
				code_q     <= pin_s2_q[2:0];
			end else begin
				cap_wait_q <= cap_wait_q + 2'h1;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			o_boot_strap_config <= `BSRS_STRAP_RESET;
		end else begin
			o_boot_strap_config <= code_q;
		end
	end

	// ======================================================================
	// power-on reset delay
	// a 32-bit counter is wide enough for any delay a parameter could ask for
	logic [31:0] por_cnt_q;

	always_ff @(posedge i_core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			por_cnt_q   <= 32'h0000_0000;
			o_por_out_n <= 1'b0;
		end else if (!pin_s2_q[3]) begin
			por_cnt_q   <= 32'h0000_0000;
			o_por_out_n <= 1'b0;
		end else if (por_cnt_q < POR_CYCLES - 1) begin
			por_cnt_q   <= por_cnt_q + 32'h0000_0001;
			o_por_out_n <= 1'b0;
		end else begin
			o_por_out_n <= 1'b1;
		end
	end

	// ======================================================================
	// boot source stepping
	bsrs_pkg::bsrs_state_t state_q;
	logic [1:0]            slot_q;
	bsrs_pkg::bsrs_src_t   src;

	bsrs_order_decode u_decode (
		.i_code (code_q),
		.i_slot (slot_q),
		.o_src  (src)
	);

	always_ff @(posedge i_core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= bsrs_pkg::BSRS_ST_IDLE;
			slot_q  <= 2'h0;
		end else begin
			case (state_q)
				bsrs_pkg::BSRS_ST_IDLE: begin
					if (i_boot_start && captured_q && o_por_out_n) begin
						state_q <= bsrs_pkg::BSRS_ST_TRY;
						slot_q  <= 2'h0;
					end
				end
				bsrs_pkg::BSRS_ST_TRY: begin
					if (i_boot_ok) begin
						state_q <= bsrs_pkg::BSRS_ST_DONE;
					end else if (i_boot_fail) begin
						if (slot_q == 2'h3) begin
							state_q <= bsrs_pkg::BSRS_ST_EXHAUSTED;
						end else begin
							slot_q <= slot_q + 2'h1;
						end
					end
				end
				bsrs_pkg::BSRS_ST_DONE: begin
					state_q <= bsrs_pkg::BSRS_ST_DONE;
				end
				bsrs_pkg::BSRS_ST_EXHAUSTED: begin
					state_q <= bsrs_pkg::BSRS_ST_EXHAUSTED;
				end
				default: begin
					state_q <= bsrs_pkg::BSRS_ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			o_boot_src       <= bsrs_pkg::BSRS_SRC_EMMC;
			o_boot_src_valid <= 1'b0;
			o_boot_done      <= 1'b0;
			o_boot_exhausted <= 1'b0;
		end else begin
			o_boot_src       <= src;
			o_boot_src_valid <= (state_q == bsrs_pkg::BSRS_ST_TRY);
			o_boot_done      <= (state_q == bsrs_pkg::BSRS_ST_DONE);
			o_boot_exhausted <= (state_q == bsrs_pkg::BSRS_ST_EXHAUSTED);
		end
	end
endmodule
`default_nettype wire

// File: tb/bsrs_board_model.sv
// board straps and external reset circuit
`timescale 1ns/1ps
`default_nettype none
module bsrs_board_model #(
	parameter int unsigned RST_HOLD = 4
) (
	input  wire logic       i_clk,
	input  wire logic       i_supply_up,
	input  wire logic       i_reset_req,
	input  wire logic [2:0] i_pull_down,
	output logic            o_arst_n,
	output logic [2:0]      o_strap
);
	// ====
	// reset held after power-up
	int unsigned cnt_q = 0;
	always @(posedge i_clk)
		if (i_supply_up && cnt_q < RST_HOLD)
			cnt_q <= cnt_q + 1;
	assign o_arst_n = cnt_q >= RST_HOLD && !i_reset_req;
	assign o_strap  = ~i_pull_down; // no pull-down fitted reads one
endmodule
`default_nettype wire

// File: tb/bsrs_top_sva.sv
// assertions on the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module bsrs_top_sva #(
	parameter int unsigned POR_CYCLES = 20
) (
	input wire logic                i_core_clk,
	input wire logic                i_arst_n,
	input wire logic                i_supply_good,
	input wire logic                i_boot_fail,
	input wire logic                o_por_out_n,
	input wire logic [2:0]          o_boot_strap_config,
	input wire bsrs_pkg::bsrs_src_t o_boot_src,
	input wire logic                o_boot_src_valid,
	input wire logic                o_boot_exhausted
);
	// ====
	// one clock domain
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n);
	wire logic [2:0] code = o_boot_strap_config;
	a_code_held: assert property (o_por_out_n && $past(o_por_out_n) |-> $stable(code))
		else $error("strap code moved");
	a_por_low: assert property (!i_supply_good [*4] |-> !o_por_out_n)
		else $error("released on low supply");
	a_por_hold: assert property (!i_supply_good [*4] ##1 i_supply_good |=> !o_por_out_n [*8])
		else $error("released too soon");
	a_por_delay: assert property ($rose(o_por_out_n) |-> $past(i_supply_good, POR_CYCLES))
		else $error("released without delay");
	a_first_src: assert property ($rose(o_boot_src_valid) |->
		o_boot_src == (!code[1] ? 2'h1 : !code[2] ? 2'h3 : {~code[0], 1'b0}))
		else $error("wrong first source");
	a_fail_step: assert property (o_boot_src_valid && i_boot_fail |->
		##[1:3] (o_boot_exhausted || o_boot_src != $past(o_boot_src)))
		else $error("no step on failure");
	a_last_src: assert property ($rose(o_boot_exhausted) |-> $past(o_boot_src) == (code[2:1] == 2'h1 ? 2'h1 : 2'h3))
		else $error("wrong last source");
	a_exh_hold: assert property (o_boot_exhausted |=> o_boot_exhausted && !o_boot_src_valid)
		else $error("exhausted dropped");
endmodule
bind bsrs_top bsrs_top_sva #(.POR_CYCLES(POR_CYCLES)) u_bsrs_top_sva (.i_core_clk, .i_arst_n, .i_supply_good,
	.i_boot_fail, .o_por_out_n, .o_boot_strap_config, .o_boot_src, .o_boot_src_valid, .o_boot_exhausted);
`default_nettype wire

// File: tb/boot_strap_reset_sequencer_test.sv
// self-checking bench for the boot strap reset sequencer
`timescale 1ns/1ps
`default_nettype none
module boot_strap_reset_sequencer_test;
	localparam int unsigned POR_N = 20;
	// sources per strap code, first slot in top bits
	localparam logic [7:0] ORDER [8] = '{8'h63, 8'h4B, 8'hE1, 8'hC9, 8'h63, 8'h4B, 8'h87, 8'h27};
	logic                clk = 1'b0;
	logic                sup = 1'b1;
	logic                rreq = 1'b1;
	logic                start = 1'b0;
	logic                fail = 1'b0;
	logic                ok = 1'b0;
	logic                vld;
	logic                done;
	logic [2:0]          pd = 3'h0;
	logic                arst_n;
	logic                por_n;
	logic                exh;
	logic [2:0]          pin;
	logic [2:0]          cfg;
	bsrs_pkg::bsrs_src_t src;
	int                  errors = 0;
	int                  checks = 0;
	always #20 clk = ~clk;
	bsrs_board_model u_bsrs_board_model (.i_clk(clk), .i_supply_up(sup), .i_reset_req(rreq), .i_pull_down(pd),
		.o_arst_n(arst_n), .o_strap(pin));
	bsrs_top #(.POR_CYCLES(POR_N)) u_bsrs_top (.i_core_clk(clk), .i_arst_n(arst_n), .i_supply_good(sup),
		.i_strap_pin_a(pin[0]), .i_strap_pin_b(pin[1]), .i_strap_pin_c(pin[2]), .i_boot_start(start),
		.i_boot_fail(fail), .i_boot_ok(ok), .o_por_out_n(por_n), .o_boot_strap_config(cfg), .o_boot_src(src),
		.o_boot_src_valid(vld), .o_boot_done(done), .o_boot_exhausted(exh));
	task automatic chk(input string what, input logic [2:0] exp, input logic [2:0] got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
		tick(2);
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ====
	// scenarios
	task automatic run_order(input logic [2:0] code);
		int i;
		pd = ~code;
		rreq = 1'b1;
		tick(4);
		rreq = 1'b0;
		tick(8);
		// pins flipped after capture must not matter
		pd = code;
		for (i = 0; i < 99 && por_n !== 1'b1; i++)
			tick(1);
		chk("strap code", code, cfg);
		pulse(start);
		for (i = 0; i < 4; i++) begin
			chk("source", {1'b0, ORDER[code][7-2*i-:2]}, {1'b0, src});
			pulse(fail);
		end
		chk("exhausted", 3'h1, {2'h0, exh});
		chk("valid after exhaust", 3'h0, {2'h0, vld});
	endtask
	task automatic run_ok();
		int i;
		pd = 3'h0;
		rreq = 1'b1;
		tick(4);
		rreq = 1'b0;
		for (i = 0; i < 99 && por_n !== 1'b1; i++)
			tick(1);
		pulse(start);
		chk("valid", 3'h1, {2'h0, vld});
		pulse(fail);
		pulse(ok);
		chk("done", 3'h1, {2'h0, done});
		chk("valid after done", 3'h0, {2'h0, vld});
		chk("source at done", {1'b0, ORDER[7][5:4]}, {1'b0, src});
		chk("not exhausted", 3'h0, {2'h0, exh});
	endtask
	task automatic por_test();
		int n;
		sup = 1'b0;
		tick(5);
		chk("reset output", 3'h0, {2'h0, por_n});
		sup = 1'b1;
		tick(10);
		sup = 1'b0;
		tick(4);
		sup = 1'b1;
		for (n = 0; n < 99 && por_n !== 1'b1; n++)
			tick(1);
		chk("release delay", 3'h1, {2'h0, n > POR_N && n < POR_N + 6});
	endtask
	initial begin
		for (int c = 0; c < 8; c++)
			run_order(3'(c));
		run_ok();
		por_test();
		end_of_test();
	end
	// run is some 420 cycles
	initial begin
		#(40 * 5000);
		errors++;
		end_of_test();
	end
endmodule
`default_nettype wire
